// ---- pkg/ptf_pkg.sv ----
// Constants and types for the converter telemetry and fault handler
package ptf_pkg;
  localparam int CLK_HZ = 25000000;
  localparam int HICCUP_MS = 130;
  localparam int HICCUP_CYC = (CLK_HZ / 1000) * HICCUP_MS;
  localparam int VOLT_W = 12;
  localparam int NARROW_W = 8;
  localparam int ADC_W = 12;
  // Register offsets
  localparam logic [3:0] REG_VOLT = 4'h0;
  localparam logic [3:0] REG_CURR = 4'h1;
  localparam logic [3:0] REG_TEMP = 4'h2;
  localparam logic [3:0] REG_CTRL = 4'h3;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam logic [3:0] REG_COMP = 4'h5;
  // Control fields
  localparam int CTRL_ON_BIT = 0;
  localparam int CTRL_INJ_BIT = 1;
  localparam int CTRL_LATCH_BIT = 2;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] COMP_RESET = 8'h10;
  localparam logic [7:0] TEMP_REF = 8'h19;
  typedef enum logic [1:0] {PTF_RUN, PTF_FAULT, PTF_HICCUP, PTF_LATCHED} ptf_state_t;
endpackage : ptf_pkg

// ---- src/ptf_handler.sv ----
// Converter telemetry sampling, fault injection and hiccup recovery
module ptf_handler
  import ptf_pkg::*;
#(
  parameter int HICCUP_CYCLES = HICCUP_CYC
)
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [ADC_W-1:0] i_adc_volt,
  input wire logic [ADC_W-1:0] i_adc_curr,
  input wire logic [ADC_W-1:0] i_adc_temp,
  input wire logic i_adc_valid,
  input wire logic i_fault_genuine,
  input wire logic i_enable_pin,
  input wire logic i_sync_data,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  output logic o_fault_status_n,
  output logic o_fault_status_oe,
  output logic o_power_on,
  output logic [VOLT_W-1:0] o_volt,
  output logic [NARROW_W-1:0] o_curr,
  output logic [NARROW_W-1:0] o_temp
);
  initial
  begin
    if (HICCUP_CYCLES < 1) $error("HICCUP_CYCLES must be at least 1");
  end

  typedef struct packed {
    logic [1:0] sd_sync;
    logic sd_prev;
    logic [1:0] en_sync;
    logic en_prev;
    logic [1:0] gf_sync;
    logic [VOLT_W-1:0] volt;
    logic [NARROW_W-1:0] curr;
    logic [NARROW_W-1:0] temp;
    logic [7:0] ctrl;
    logic [7:0] comp;
    ptf_state_t state;
    logic [31:0] cnt;
    logic fault_pend;
    logic fs_n;
    logic fs_oe;
    logic [7:0] rdata;
    logic power_on;
  } ptf_regs_t;

  ptf_regs_t r;
  ptf_regs_t next_r;
  logic sd_fall;
  logic en_rise;
  logic trigger;

  // Temperature correction of current: scale by ESR drift slope
  function automatic logic [NARROW_W-1:0] ptf_comp_curr(input logic [7:0] c, input logic [7:0] t,
                                                       input logic [7:0] k);
    logic [15:0] delta;
    logic [15:0] prod;
    logic [16:0] sum;
    delta = 16'h0000;
    prod = 16'h0000;
    sum = 17'h00000;
    if (t > TEMP_REF)
    begin
      delta = {8'h00, t - TEMP_REF};
      prod = 16'((32'(c) * 32'(delta) * 32'(k)) >> 8);
      sum = 17'(c) - 17'(prod >> 4);
      if (prod[15:4] > {4'h0, c}) sum = 17'h00000;
    end
    else
    begin
      sum = 17'(c);
    end
    return sum[7:0];
  endfunction

  assign sd_fall = r.sd_prev & ~r.sd_sync[1];
  assign en_rise = ~r.en_prev & r.en_sync[1];
  assign trigger = r.gf_sync[1] | r.ctrl[CTRL_INJ_BIT];

  // Next-state logic
  always_comb
  begin
    next_r = r;
    next_r.sd_sync = {r.sd_sync[0], i_sync_data};
    next_r.sd_prev = r.sd_sync[1];
    next_r.en_sync = {r.en_sync[0], i_enable_pin};
    next_r.en_prev = r.en_sync[1];
    next_r.gf_sync = {r.gf_sync[0], i_fault_genuine};
    // Continuous sampling, independent of any polling
    if (i_adc_valid)
    begin
      next_r.volt = i_adc_volt;
      next_r.temp = i_adc_temp[ADC_W-1 -: NARROW_W];
      next_r.curr = ptf_comp_curr(i_adc_curr[ADC_W-1 -: NARROW_W], i_adc_temp[ADC_W-1 -: NARROW_W],
                                  r.comp);
    end
    // Register writes; injection holds until cleared
    if (i_wr && i_addr == REG_CTRL)
    begin
      next_r.ctrl = i_wdata;
    end
    if (i_wr && i_addr == REG_COMP)
    begin
      next_r.comp = i_wdata;
    end
    // Read data, one cycle later
    next_r.rdata = 8'h00;
    if (i_rd)
    begin
      case (i_addr)
        REG_VOLT: next_r.rdata = r.volt[7:0];
        REG_CURR: next_r.rdata = r.curr;
        REG_TEMP: next_r.rdata = r.temp;
        REG_CTRL: next_r.rdata = r.ctrl;
        REG_STAT: next_r.rdata = {4'h0, r.volt[11:8] == 4'h0 ? 1'b0 : 1'b1, r.power_on,
                                  2'(r.state)};
        REG_COMP: next_r.rdata = r.comp;
        default: next_r.rdata = 8'h00;
      endcase
    end
    // Fault recovery state machine
    case (r.state)
      PTF_RUN:
      begin
        next_r.power_on = r.ctrl[CTRL_ON_BIT] & r.en_sync[1];
        if (trigger && r.power_on)
        begin
          next_r.state = PTF_FAULT;
          next_r.power_on = 1'b0;
          next_r.fault_pend = 1'b1;
        end
      end
      PTF_FAULT:
      begin
        next_r.power_on = 1'b0;
        if (!trigger)
        begin
          next_r.state = r.ctrl[CTRL_LATCH_BIT] ? PTF_LATCHED : PTF_HICCUP;
          next_r.cnt = 32'h00000000;
        end
      end
      PTF_HICCUP:
      begin
        next_r.power_on = 1'b0;
        if (trigger)
        begin
          next_r.state = PTF_FAULT;
        end
        else if (r.cnt >= 32'(HICCUP_CYCLES - 1))
        begin
          next_r.state = PTF_RUN;
          next_r.fault_pend = 1'b0;
        end
        else
        begin
          next_r.cnt = r.cnt + 32'h00000001;
        end
      end
      PTF_LATCHED:
      begin
        next_r.power_on = 1'b0;
        if (!trigger && (en_rise || (i_wr && i_addr == REG_CTRL && !r.ctrl[CTRL_ON_BIT]
            && i_wdata[CTRL_ON_BIT])))
        begin
          next_r.state = PTF_RUN;
          next_r.fault_pend = 1'b0;
        end
      end
      default: next_r.state = PTF_RUN;
    endcase
    // Fault status line updates only on sync falling edge
    if (sd_fall)
    begin
      next_r.fs_n = ~r.fault_pend;
      next_r.fs_oe = r.fault_pend; // Drive the open-drain line only while low
    end
  end

  // State register
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      r <= '0;
      r.ctrl <= CTRL_RESET;
      r.comp <= COMP_RESET;
      r.state <= PTF_RUN;
      r.fs_n <= 1'b1;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign o_rdata = r.rdata;
  assign o_fault_status_n = r.fs_n;
  assign o_fault_status_oe = r.fs_oe;
  assign o_power_on = r.power_on;
  assign o_volt = r.volt;
  assign o_curr = r.curr;
  assign o_temp = r.temp;

  // Fault status moves only after a sync falling edge
  property p_fs_edge;
    @(posedge i_clk) disable iff (i_reset)
      (r.fs_n != $past(r.fs_n)) |-> $past(sd_fall);
  endproperty
  a_fs_edge: assert property (p_fs_edge) else $error("fault line changed off sync edge");

  property p_fault_off;
    @(posedge i_clk) disable iff (i_reset)
      (r.state == PTF_RUN && trigger && r.power_on) |=> (!r.power_on && r.state == PTF_FAULT);
  endproperty
  a_fault_off: assert property (p_fault_off) else $error("fault did not shut output");

  property p_latch_hold;
    @(posedge i_clk) disable iff (i_reset)
      (r.state == PTF_LATCHED && !en_rise && !i_wr) |=> (r.state == PTF_LATCHED && !r.power_on);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latched fault released");

  property p_hiccup_off;
    @(posedge i_clk) disable iff (i_reset)
      (r.state == PTF_HICCUP) |-> !r.power_on;
  endproperty
  a_hiccup_off: assert property (p_hiccup_off) else $error("output on during hiccup");

  property p_hiccup_end;
    @(posedge i_clk) disable iff (i_reset)
      (r.state == PTF_HICCUP && !trigger && r.cnt == 32'(HICCUP_CYCLES - 1)) |=> r.state == PTF_RUN;
  endproperty
  a_hiccup_end: assert property (p_hiccup_end) else $error("hiccup restart missed");

  property p_sample;
    @(posedge i_clk) disable iff (i_reset)
      i_adc_valid |=> (r.volt == $past(i_adc_volt));
  endproperty
  a_sample: assert property (p_sample) else $error("voltage sample not stored");

  property p_inj_hold;
    @(posedge i_clk) disable iff (i_reset)
      (r.ctrl[CTRL_INJ_BIT] && !(i_wr && i_addr == REG_CTRL)) |=> r.ctrl[CTRL_INJ_BIT];
  endproperty
  a_inj_hold: assert property (p_inj_hold) else $error("injection dropped by itself");

  property p_rd_volt;
    @(posedge i_clk) disable iff (i_reset)
      (i_rd && i_addr == REG_VOLT) |=> (o_rdata == $past(r.volt[7:0]));
  endproperty
  a_rd_volt: assert property (p_rd_volt) else $error("voltage read wrong");

  // Read port: data stands one cycle, zero otherwise
  property p_rdata_idle;
    @(posedge i_clk) disable iff (i_reset)
      !i_rd |=> (o_rdata == 8'h00);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not cleared");

  property p_rd_curr;
    @(posedge i_clk) disable iff (i_reset)
      (i_rd && i_addr == REG_CURR) |=> (o_rdata == $past(r.curr));
  endproperty
  a_rd_curr: assert property (p_rd_curr) else $error("current read wrong");

  property p_rd_temp;
    @(posedge i_clk) disable iff (i_reset)
      (i_rd && i_addr == REG_TEMP) |=> (o_rdata == $past(r.temp));
  endproperty
  a_rd_temp: assert property (p_rd_temp) else $error("temperature read wrong");

  // Sampling and current correction
  property p_temp_sample;
    @(posedge i_clk) disable iff (i_reset)
      i_adc_valid |=> (r.temp == $past(i_adc_temp[ADC_W-1 -: NARROW_W]));
  endproperty
  a_temp_sample: assert property (p_temp_sample) else $error("temperature sample not stored");

  property p_curr_cold;
    @(posedge i_clk) disable iff (i_reset)
      (i_adc_valid && i_adc_temp[ADC_W-1 -: NARROW_W] <= TEMP_REF)
        |=> (r.curr == $past(i_adc_curr[ADC_W-1 -: NARROW_W]));
  endproperty
  a_curr_cold: assert property (p_curr_cold) else $error("current changed below reference");

  property p_curr_warm;
    @(posedge i_clk) disable iff (i_reset)
      (i_adc_valid && i_adc_temp[ADC_W-1 -: NARROW_W] > TEMP_REF)
        |=> (r.curr <= $past(i_adc_curr[ADC_W-1 -: NARROW_W]));
  endproperty
  a_curr_warm: assert property (p_curr_warm) else $error("warm current not reduced");

  // Fault recovery sequencing
  property p_fault_stay;
    @(posedge i_clk) disable iff (i_reset)
      (r.state == PTF_FAULT && trigger) |=> (r.state == PTF_FAULT && !r.power_on);
  endproperty
  a_fault_stay: assert property (p_fault_stay) else $error("fault left while trigger high");

  property p_fault_exit;
    @(posedge i_clk) disable iff (i_reset)
      (r.state == PTF_FAULT && !trigger)
        |=> (r.state == ($past(r.ctrl[CTRL_LATCH_BIT]) ? PTF_LATCHED : PTF_HICCUP));
  endproperty
  a_fault_exit: assert property (p_fault_exit) else $error("wrong recovery after fault");

  property p_hiccup_retrig;
    @(posedge i_clk) disable iff (i_reset)
      (r.state == PTF_HICCUP && trigger) |=> (r.state == PTF_FAULT);
  endproperty
  a_hiccup_retrig: assert property (p_hiccup_retrig) else $error("hiccup ignored new fault");

  property p_latch_en;
    @(posedge i_clk) disable iff (i_reset)
      (r.state == PTF_LATCHED && !trigger && en_rise) |=> (r.state == PTF_RUN);
  endproperty
  a_latch_en: assert property (p_latch_en) else $error("enable toggle did not clear");

  property p_latch_cmd;
    @(posedge i_clk) disable iff (i_reset)
      (r.state == PTF_LATCHED && !trigger && i_wr && i_addr == REG_CTRL && !r.ctrl[CTRL_ON_BIT]
        && i_wdata[CTRL_ON_BIT]) |=> (r.state == PTF_RUN);
  endproperty
  a_latch_cmd: assert property (p_latch_cmd) else $error("off-on command did not clear");

  property p_run_power;
    @(posedge i_clk) disable iff (i_reset)
      (r.state == PTF_RUN && !trigger) |=> (r.power_on == $past(r.ctrl[CTRL_ON_BIT] & r.en_sync[1]));
  endproperty
  a_run_power: assert property (p_run_power) else $error("output does not follow enable");

  // Fault status line handling
  property p_fs_pend;
    @(posedge i_clk) disable iff (i_reset)
      sd_fall |=> (r.fs_n == !$past(r.fault_pend));
  endproperty
  a_fs_pend: assert property (p_fs_pend) else $error("fault line not updated on sync edge");

  property p_oe_pair;
    @(posedge i_clk) disable iff (i_reset)
      (o_fault_status_oe == !o_fault_status_n);
  endproperty
  a_oe_pair: assert property (p_oe_pair) else $error("fault line enable mismatched");

endmodule : ptf_handler

// ---- tb/ptf_handler_bench.sv ----
// Self-checking bench for the telemetry and fault handler
module ptf_handler_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import ptf_pkg::*;
  localparam int HC = 20;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] av = 12'h000;
  logic [11:0] ac = 12'h000;
  logic [11:0] at = 12'h000;
  logic avld = 1'b0;
  logic flt = 1'b0;
  logic en = 1'b0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wd = 8'h00;
  logic sync;
  logic seen;
  logic [7:0] rdata;
  logic fn;
  logic foe;
  logic pon;
  logic [11:0] vo;
  logic [7:0] co;
  logic [7:0] to;
  logic [7:0] expq[$];
  logic rd_d = 1'b0;
  logic mhold;
  logic gon;
  logic [11:0] mv;
  logic [7:0] mc;
  logic [7:0] mt;
  logic ms;
  logic sync_d = 1'b1;
  logic fn_d = 1'b1;
  logic mon = 1'b0;
  logic [3:0] since = 4'h0;
  logic [31:0] lfsr = 32'h16D6;
  logic [7:0] ec;
  int errors = 0;
  int check_count = 0;

  ptf_handler #(.HICCUP_CYCLES(HC)) ptf_handler_inst (.i_clk(clk), .i_reset(rst), .i_adc_volt(av),
    .i_adc_curr(ac), .i_adc_temp(at), .i_adc_valid(avld), .i_fault_genuine(flt), .i_enable_pin(en),
    .i_sync_data(sync), .i_addr(addr), .i_wdata(wd), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .o_fault_status_n(fn), .o_fault_status_oe(foe), .o_power_on(pon), .o_volt(vo), .o_curr(co), .o_temp(to));
  ptf_mgr_model ptf_mgr_model_inst (.i_clk(clk), .i_fault_n(fn), .i_fault_oe(foe), .i_volt(vo), .i_curr(co),
    .i_temp(to), .i_power_on(pon), .o_sync(sync), .o_fault_seen(seen), .o_hold(mhold), .o_group_on(gon),
    .o_mon_volt(mv), .o_mon_curr(mc), .o_mon_temp(mt), .o_mon_stat(ms));

  // Clock generator
  always #20 clk = ~clk;

  function automatic logic [31:0] nxt(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(string n, logic [11:0] e, logic [11:0] s);
    check_count++;
    if (s !== e)
    begin
      errors++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask

  task automatic wreg(logic [3:0] a, logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rreg(logic [3:0] a, logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    expq.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
  endtask

  task automatic wait_pon(int n, logic e);
    repeat (n) @(posedge clk);
    chk("power_on", {11'h000, e}, {11'h000, pon});
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Read data watcher, one cycle after the read strobe
  always @(posedge clk)
  begin
    rd_d <= rd;
  end
  always @(negedge clk)
  begin
    if (rd_d)
      chk("rdata", {4'h0, expq.pop_front()}, {4'h0, rdata});
  end

  // Fault line may only move shortly after a sync falling edge
  always @(posedge clk)
  begin
    sync_d <= sync;
    since <= (sync_d && !sync) ? 4'h0 : (since == 4'hF ? since : since + 4'h1);
    fn_d <= fn;
    if (mon && fn !== fn_d && since > 4'h5)
      chk("fault_edge", {11'h000, fn_d}, {11'h000, fn});
  end

  // Watchdog
  initial
  begin
    #80000;
    errors++;
    finish_test();
  end

  // Main sequence
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rreg(REG_COMP, COMP_RESET);
    rreg(REG_CTRL, CTRL_RESET);
    rreg(4'hF, 8'h00);
    mon <= 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      lfsr = nxt(lfsr);
      @(posedge clk);
      av <= (i == 4) ? 12'h123 : lfsr[11:0];
      ac <= (i == 4) ? 12'hC80 : lfsr[23:12];
      at <= (i == 4) ? 12'h290 : {4'h0, lfsr[31:24]};
      ec = (i == 4) ? 8'hBC : lfsr[23:16];
      avld <= 1'b1;
      @(posedge clk);
      avld <= 1'b0;
      repeat (4) @(posedge clk);
      chk("volt", av, vo);
      chk("curr", {4'h0, ec}, {4'h0, co});
      chk("temp", {4'h0, at[11:4]}, {4'h0, to});
      rreg(REG_VOLT, av[7:0]);
      rreg(REG_STAT, {4'h0, |av[11:8], 3'b000});
    end
    repeat (66) @(posedge clk);
    chk("mon_volt", 12'h123, mv);
    chk("mon_curr", 12'h0BC, {4'h0, mc});
    chk("mon_temp", 12'h029, {4'h0, mt});
    chk("hold", {11'h000, ~sync}, {11'h000, mhold});
    $display("telemetry test ended");
    en <= 1'b1;
    wreg(REG_CTRL, 8'h01);
    wait_pon(4, 1'b1);
    wreg(REG_CTRL, 8'h03);
    wait_pon(3, 1'b0);
    rreg(REG_STAT, 8'h09);
    repeat (20) @(posedge clk);
    chk("fault_line", 12'h000, {11'h000, fn});
    chk("fault_seen", 12'h001, {11'h000, seen});
    wreg(REG_CTRL, 8'h01);
    wait_pon(HC - 4, 1'b0);
    wait_pon(12, 1'b1);
    $display("hiccup test ended");
    wreg(REG_CTRL, 8'h05);
    flt <= 1'b1;
    wait_pon(5, 1'b0);
    flt <= 1'b0;
    wait_pon(HC + 10, 1'b0);
    rreg(REG_STAT, 8'h0B);
    en <= 1'b0;
    repeat (5) @(posedge clk);
    en <= 1'b1;
    wait_pon(8, 1'b1);
    wreg(REG_CTRL, 8'h07);
    wreg(REG_CTRL, 8'h05);
    wait_pon(HC + 10, 1'b0);
    wreg(REG_CTRL, 8'h04);
    wreg(REG_CTRL, 8'h05);
    wait_pon(4, 1'b1);
    $display("latch test ended");
    repeat (66) @(posedge clk);
    chk("mon_stat", 12'h001, {11'h000, ms});
    chk("group_on", 12'h001, {11'h000, gon});
    $display("monitor test ended");
    finish_test();
  end
endmodule // ptf_handler_bench

// ---- tb/ptf_mgr_model.sv ----
// Power manager model driving the shared sync data line
module ptf_mgr_model
#(
  parameter int REFRESH_CYCLES = 64,
  parameter bit AUTO_ON = 1'b1,
  parameter bit POLL_PARAM = 1'b1,
  parameter bit POLL_STATUS = 1'b1
)
(
  input wire logic i_clk,
  input wire logic i_fault_n,
  input wire logic i_fault_oe,
  input wire logic [11:0] i_volt,
  input wire logic [7:0] i_curr,
  input wire logic [7:0] i_temp,
  input wire logic i_power_on,
  output logic o_sync,
  output logic o_fault_seen,
  output logic o_hold,
  output logic o_group_on,
  output logic [11:0] o_mon_volt,
  output logic [7:0] o_mon_curr,
  output logic [7:0] o_mon_temp,
  output logic o_mon_stat
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  // Master clock on the sync line, 320 ns period
  initial o_sync = 1'b1;
  always #160 o_sync = ~o_sync;
  // Pulled-up fault line, low seen whatever the poll options
  assign o_fault_seen = i_fault_oe && !i_fault_n;
  // Host access held off while the sync line is busy
  assign o_hold = !o_sync;
  // Periodic refresh, short stand-in for the one-second period; group options steer only this side
  always @(posedge i_clk)
  begin
    cnt <= (cnt == REFRESH_CYCLES - 1) ? 0 : cnt + 1;
    if (cnt == REFRESH_CYCLES - 1)
    begin
      o_group_on <= AUTO_ON;
      if (POLL_PARAM)
      begin
        o_mon_volt <= i_volt;
        o_mon_curr <= i_curr;
        o_mon_temp <= i_temp;
      end
      if (POLL_STATUS)
        o_mon_stat <= i_power_on;
    end
  end
endmodule // ptf_mgr_model
